// >>> rtl/tcc_compare_channel.sv
`timescale 1ns/1ps
// ======================================================================
// one output compare channel: two latches, match detect, waveform
module tcc_compare_channel
  import tcc_pkg::*;
(
  // clock and reset
  input wire logic clock_i,
  input wire logic srst_i,
  // selected source timer
  input wire logic [CNT_W-1:0] count_i,
  input wire logic [CNT_W-1:0] reload_val_i,
  input wire logic underflow_i,
  input wire logic running_i,
  // compare register write and latch reload
  input wire logic [1:0] wr_en_i,
  input wire logic [CNT_W-1:0] wr_data_i,
  input wire logic [1:0] reload_req_i,
  // channel settings
  input wire logic trig_en_i,
  input wire logic neg_level_i,
  // results
  output logic [1:0] match_o,
  output logic level_o
);
  logic [CNT_W-1:0] creg_q [2];
  logic [CNT_W-1:0] latch_q [2];
  logic [1:0] pend_q;
  logic [1:0] hit;
  logic [1:0] hit_q;

  // ======================================================================
  // compare register, latch and pending reload per latch
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      for (int l = 0; l < 2; l++) begin
        creg_q[l] <= LATCH_RST;
        latch_q[l] <= LATCH_RST;
      end
      pend_q <= '0;
    end else begin
      for (int l = 0; l < 2; l++) begin
        if (wr_en_i[l]) begin
          creg_q[l] <= wr_data_i;
        end
        if (!running_i && wr_en_i[l]) begin
          latch_q[l] <= wr_data_i;
          pend_q[l] <= 1'b0;
        end else if (!running_i && (pend_q[l] || reload_req_i[l])) begin
          latch_q[l] <= creg_q[l];
          pend_q[l] <= 1'b0;
        end else if (underflow_i && pend_q[l]) begin
          latch_q[l] <= creg_q[l];
          pend_q[l] <= reload_req_i[l];
        end else if (reload_req_i[l]) begin
          pend_q[l] <= 1'b1;
        end
      end
    end
  end

  // out-of-range latch never matches; each latch judged alone
  always_comb begin
    for (int l = 0; l < 2; l++) begin
      hit[l] = (count_i == latch_q[l]) && (latch_q[l] <= reload_val_i);
    end
  end

  // match fires once per arrival, not every cycle a stopped timer sits
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      hit_q <= '0;
      match_o <= '0;
    end else begin
      hit_q <= hit;
      match_o <= hit & ~hit_q;
    end
  end

  // ======================================================================
  // waveform; equal latches are illegal, x1 wins if it ever happens
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      level_o <= LEVEL_RST;
    end else if (trig_en_i) begin
      if (hit[LAT_X1] && !hit_q[LAT_X1]) begin
        level_o <= neg_level_i;
      end else if (hit[LAT_X0] && !hit_q[LAT_X0]) begin
        level_o <= ~neg_level_i;
      end
    end
  end
endmodule : tcc_compare_channel

// >>> rtl/tcc_noise_filter.sv
`timescale 1ns/1ps
// ======================================================================
// two-flop synchroniser plus consecutive-sample filter for one input
module tcc_noise_filter
  import tcc_pkg::*;
#(
  parameter int LEN = FILT_LEN
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic srst_i,
  // raw pin and control
  input wire logic pin_i,
  input wire logic sample_en_i,
  input wire logic bypass_i,
  // filtered level
  output logic level_o
);
  logic sync1_q;
  logic sync2_q;
  logic [LEN-1:0] hist_q;

  // ======================================================================
  // synchroniser, first flop feeds only the second
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else begin
      sync1_q <= pin_i;
      sync2_q <= sync1_q;
    end
  end

  // ======================================================================
  // sample history, shifted on each sampling tick
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      hist_q <= '0;
    end else if (sample_en_i || bypass_i) begin
      hist_q <= {hist_q[LEN-2:0], sync2_q};
    end
  end

  // new level only after all samples agree; bypass while filter stopped
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      level_o <= LEVEL_RST;
    end else if (bypass_i) begin
      level_o <= sync2_q;
    end else if (hist_q == {LEN{1'b1}}) begin
      level_o <= 1'b1;
    end else if (hist_q == {LEN{1'b0}}) begin
      level_o <= 1'b0;
    end
  end
endmodule : tcc_noise_filter

// >>> rtl/tcc_top.sv
`timescale 1ns/1ps
// ======================================================================
// timer capture/compare unit top

// How it works
// - writes while the source timer is stopped go straight into the latch.
// - a latch above the timer reload value never matches.
// - the in-range latch still matches and interrupts when the other cannot.
// - trigger enable off freezes the waveform but matches still signal.
// - two capture channels, each picks timer A or B by its own bit.
// - filtered rising edge stores count in x0, falling edge in x1.
// - each of four software trigger strobes stores the count in its latch.
// - software trigger bits read back as zero.
// - per channel status bit shows which latch was written last.
// - edge select gates only the interrupt, both edges always capture.
// - filter takes a new level after four equal samples.
// - filter code 00 stops the filter; software uses it for stop wake.
// - read pointer picks the latch shown on the shared byte pair.
// - a capture between byte reads can mix values; software rereads.
// - coincident triggers leave the status bit naming x1 as the latest.
// - both timers and all latches are sixteen bits wide.
// - reload bit while running loads the latch at next underflow.
module tcc_top
  import tcc_pkg::*;
(
  // clock and reset
  input wire logic clock_i,
  input wire logic srst_i,
  // timer a, same clock domain
  input wire logic [CNT_W-1:0] tmr_a_count_i,
  input wire logic [CNT_W-1:0] tmr_a_reload_i,
  input wire logic tmr_a_underflow_i,
  input wire logic tmr_a_running_i,
  // timer b, same clock domain
  input wire logic [CNT_W-1:0] tmr_b_count_i,
  input wire logic [CNT_W-1:0] tmr_b_reload_i,
  input wire logic tmr_b_underflow_i,
  input wire logic tmr_b_running_i,
  // compare register write
  input wire logic [CMP_PTR_W-1:0] cmp_wr_ptr_i,
  input wire logic [7:0] cmp_wr_byte_i,
  input wire logic cmp_wr_lo_i,
  input wire logic cmp_wr_hi_i,
  input wire logic [CMP_LAT-1:0] cmp_reload_i,
  // compare settings
  input wire logic [CMP_CH-1:0] cmp_src_sel_i,
  input wire logic [CMP_CH-1:0] cmp_trig_en_i,
  input wire logic [CMP_CH-1:0] cmp_neg_level_i,
  input wire logic [CMP_LAT-1:0] cmp_irq_src_i,
  // compare results
  output logic [CMP_CH-1:0] cmp_out_o,
  output logic [CMP_LAT-1:0] cmp_match_o,
  output logic [CMP_LAT-1:0] cmp_irq_o,
  // capture pins
  input wire logic capture_input_zero_i,
  input wire logic capture_input_one_i,
  // capture settings
  input wire logic [CAP_CH-1:0] cap_src_sel_i,
  input wire logic [2*CAP_CH-1:0] cap_edge_sel_i,
  input wire logic [2*CAP_CH-1:0] cap_filt_sel_i,
  input wire logic [CAP_LAT-1:0] cap_sw_trig_i,
  input wire logic [CAP_PTR_W-1:0] cap_rd_ptr_i,
  // capture results
  output logic [7:0] cap_rd_lo_o,
  output logic [7:0] cap_rd_hi_o,
  output logic [CAP_CH-1:0] cap_status_o,
  output logic [CAP_CH-1:0] cap_irq_o,
  output logic [CAP_LAT-1:0] cap_sw_trig_rd_o
);

  // ======================================================================
  // compare register write staging
  logic [7:0] wr_lo_q;
  logic [CNT_W-1:0] wr_word;

  // low byte first, high byte completes the word
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      wr_lo_q <= 8'h00;
    end else if (cmp_wr_lo_i) begin
      wr_lo_q <= cmp_wr_byte_i;
    end
  end

  assign wr_word = {cmp_wr_byte_i, wr_lo_q};

  // ======================================================================
  // compare channels
  logic [CMP_LAT-1:0] match;

  for (genvar g = 0; g < CMP_CH; g++) begin : g_cmp
    logic [1:0] wr_en;
    logic sel_b;

    assign sel_b = (cmp_src_sel_i[g] == SRC_TIMER_B);
    for (genvar l = 0; l < 2; l++) begin : g_lat
      assign wr_en[l] = cmp_wr_hi_i &&
                        (cmp_wr_ptr_i == CMP_PTR_W'(2 * g + l));
    end

    tcc_compare_channel u_chan (
      .clock_i(clock_i),
      .srst_i(srst_i),
      .count_i(sel_b ? tmr_b_count_i : tmr_a_count_i),
      .reload_val_i(sel_b ? tmr_b_reload_i : tmr_a_reload_i),
      .underflow_i(sel_b ? tmr_b_underflow_i : tmr_a_underflow_i),
      .running_i(sel_b ? tmr_b_running_i : tmr_a_running_i),
      .wr_en_i(wr_en),
      .wr_data_i(wr_word),
      .reload_req_i(cmp_reload_i[2*g+1:2*g]),
      .trig_en_i(cmp_trig_en_i[g]),
      .neg_level_i(cmp_neg_level_i[g]),
      .match_o(match[2*g+1:2*g]),
      .level_o(cmp_out_o[g])
    );
  end

  // match events and gated interrupt requests, both registered
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      cmp_match_o <= '0;
      cmp_irq_o <= '0;
    end else begin
      cmp_match_o <= match;
      cmp_irq_o <= match & cmp_irq_src_i;
    end
  end

  // ======================================================================
  // filter sampling ticks from one free divider
  logic [DIV_W-1:0] div_q;
  logic tick8_q;
  logic tick32_q;

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      div_q <= '0;
      tick8_q <= 1'b0;
      tick32_q <= 1'b0;
    end else begin
      div_q <= div_q + 1'b1;
      tick8_q <= (div_q[DIV8_SH-1:0] == '0);
      tick32_q <= (div_q[DIV32_SH-1:0] == '0);
    end
  end

  // ======================================================================
  // capture input filters
  logic [CAP_CH-1:0] pins;
  logic [CAP_CH-1:0] filt;
  logic [CAP_CH-1:0] filt_q;
  logic [CAP_CH-1:0] samp_en;

  assign pins = {capture_input_one_i, capture_input_zero_i};

  for (genvar c = 0; c < CAP_CH; c++) begin : g_filt
    logic [1:0] code;

    assign code = cap_filt_sel_i[2*c+1:2*c];
    always_comb begin
      unique case (code)
        FILT_STOP: samp_en[c] = 1'b0;
        FILT_DIV1: samp_en[c] = 1'b1;
        FILT_DIV8: samp_en[c] = tick8_q;
        FILT_DIV32: samp_en[c] = tick32_q;
      endcase
    end

    // changing the code may step the level and so raise an edge
    tcc_noise_filter #(
      .LEN(FILT_LEN)
    ) u_filt (
      .clock_i(clock_i),
      .srst_i(srst_i),
      .pin_i(pins[c]),
      .sample_en_i(samp_en[c]),
      .bypass_i(code == FILT_STOP),
      .level_o(filt[c])
    );
  end

  // ======================================================================
  // capture latches, status and interrupt
  logic [CNT_W-1:0] cap_q [CAP_LAT];
  logic [CAP_CH-1:0] rise;
  logic [CAP_CH-1:0] fall;

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      filt_q <= '0;
    end else begin
      filt_q <= filt;
    end
  end

  assign rise = filt & ~filt_q;
  assign fall = ~filt & filt_q;

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      for (int i = 0; i < CAP_LAT; i++) begin
        cap_q[i] <= CAP_RST;
      end
      cap_status_o <= '0;
    end else begin
      for (int c = 0; c < CAP_CH; c++) begin
        logic [CNT_W-1:0] cnt;
        logic t0;
        logic t1;
        cnt = (cap_src_sel_i[c] == SRC_TIMER_B) ?
              tmr_b_count_i : tmr_a_count_i;
        t0 = rise[c] || cap_sw_trig_i[2*c+LAT_X0];
        t1 = fall[c] || cap_sw_trig_i[2*c+LAT_X1];
        if (t0) begin
          cap_q[2*c+LAT_X0] <= cnt;
        end
        if (t1) begin
          cap_q[2*c+LAT_X1] <= cnt;
        end
        // coincident triggers: x1 taken as latest
        if (t1) begin
          cap_status_o[c] <= 1'(LAT_X1);
        end else if (t0) begin
          cap_status_o[c] <= 1'(LAT_X0);
        end
      end
    end
  end

  // interrupt only on the chosen edges; capture is unaffected
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      cap_irq_o <= '0;
    end else begin
      for (int c = 0; c < CAP_CH; c++) begin
        cap_irq_o[c] <= (rise[c] && cap_edge_sel_i[2*c+EDGE_RISE_BIT]) ||
                        (fall[c] && cap_edge_sel_i[2*c+EDGE_FALL_BIT]);
      end
    end
  end

  // ======================================================================
  // shared read pair, live view so a capture between reads can tear
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      cap_rd_lo_o <= 8'h00;
      cap_rd_hi_o <= 8'h00;
    end else begin
      cap_rd_lo_o <= cap_q[cap_rd_ptr_i][7:0];
      cap_rd_hi_o <= cap_q[cap_rd_ptr_i][15:8];
    end
  end

  // trigger bits are strobes only, nothing is stored to read back
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      cap_sw_trig_rd_o <= '0;
    end else begin
      cap_sw_trig_rd_o <= '0;
    end
  end
endmodule : tcc_top

// >>> shared/tcc_pkg.sv
// ======================================================================
// shared constants for the timer capture/compare unit
package tcc_pkg;
  // count width of both source timers
  localparam int CNT_W = 16;
  // compare side: four channels of two latches each
  localparam int CMP_CH = 4;
  localparam int CMP_LAT = 2 * CMP_CH;
  localparam int CMP_PTR_W = 3;
  // capture side: two channels of two latches each
  localparam int CAP_CH = 2;
  localparam int CAP_LAT = 2 * CAP_CH;
  localparam int CAP_PTR_W = 2;
  // latch index within a channel
  localparam int LAT_X0 = 0;
  localparam int LAT_X1 = 1;
  // source select encoding
  localparam logic SRC_TIMER_A = 1'b0;
  localparam logic SRC_TIMER_B = 1'b1;
  // interrupt edge select field positions
  localparam int EDGE_RISE_BIT = 0;
  localparam int EDGE_FALL_BIT = 1;
  // noise filter
  localparam int FILT_LEN = 4;
  localparam logic [1:0] FILT_STOP = 2'b00;
  localparam logic [1:0] FILT_DIV1 = 2'b01;
  localparam logic [1:0] FILT_DIV8 = 2'b10;
  localparam logic [1:0] FILT_DIV32 = 2'b11;
  localparam int DIV_W = 5;
  localparam int DIV8_SH = 3;
  localparam int DIV32_SH = 5;
  // reset values
  localparam logic [CNT_W-1:0] LATCH_RST = 16'hffff;
  localparam logic [CNT_W-1:0] CAP_RST = 16'h0000;
  localparam logic LEVEL_RST = 1'b0;
endpackage : tcc_pkg

// >>> sim/tcc_monitor.sv
`timescale 1ns/1ps
// ======================================================================
// port checker for the capture/compare unit
module tcc_monitor
  import tcc_pkg::*;
(
  // clock and reset
  input wire logic clock_i,
  input wire logic srst_i,
  // inputs watched
  input wire logic [CNT_W-1:0] tmr_a_count_i,
  input wire logic [CNT_W-1:0] tmr_b_count_i,
  input wire logic [CMP_CH-1:0] cmp_trig_en_i,
  input wire logic [CMP_LAT-1:0] cmp_irq_src_i,
  input wire logic [CAP_CH-1:0] cap_src_sel_i,
  input wire logic [2*CAP_CH-1:0] cap_edge_sel_i,
  input wire logic [CAP_LAT-1:0] cap_sw_trig_i,
  input wire logic [CAP_PTR_W-1:0] cap_rd_ptr_i,
  // outputs watched
  input wire logic [CMP_CH-1:0] cmp_out_o,
  input wire logic [CMP_LAT-1:0] cmp_match_o,
  input wire logic [CMP_LAT-1:0] cmp_irq_o,
  input wire logic [7:0] cap_rd_lo_o,
  input wire logic [7:0] cap_rd_hi_o,
  input wire logic [CAP_CH-1:0] cap_status_o,
  input wire logic [CAP_CH-1:0] cap_irq_o,
  input wire logic [CAP_LAT-1:0] cap_sw_trig_rd_o
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (srst_i);
  // ======================================================================
  // assertions
  trig_rd_zero_a: assert property (
    cap_sw_trig_rd_o == 4'h0) else $error("trigger bits read nonzero");
  level_hold_a: assert property (
    (~cmp_trig_en_i & ~$past(cmp_trig_en_i)
    & (cmp_out_o ^ $past(cmp_out_o))) == 4'h0)
    else $error("waveform moved with trigger off");
  irq_gate_a: assert property (
    cmp_irq_src_i == $past(cmp_irq_src_i)
    |-> cmp_irq_o == (cmp_match_o & cmp_irq_src_i))
    else $error("compare irq not match and enable");
  // a level change must be followed by its match pulse
  out_cause_a: assert property (
    $changed(cmp_out_o[0]) |=> cmp_match_o[1:0] != 2'h0)
    else $error("waveform changed without a match");
  last_latch_a: assert property (
    cap_sw_trig_i[0] != cap_sw_trig_i[1]
    |=> cap_status_o[0] == $past(cap_sw_trig_i[1]))
    else $error("status does not name latest latch");
  irq_edge_off_a: assert property (
    cap_edge_sel_i == 4'h0 && $past(cap_edge_sel_i) == 4'h0
    && cap_sw_trig_i == 4'h0 && $past(cap_sw_trig_i) == 4'h0
    |-> cap_irq_o == 2'h0) else $error("capture irq with edges off");
  cap_a_read_a: assert property (
    (cap_sw_trig_i == 4'h1 && cap_rd_ptr_i == 2'h0
    && cap_src_sel_i[0] == SRC_TIMER_A) ##1 cap_rd_ptr_i == 2'h0
    |=> {cap_rd_hi_o, cap_rd_lo_o} == $past(tmr_a_count_i, 2))
    else $error("timer a capture wrong");
  cap_b_read_a: assert property (
    (cap_sw_trig_i == 4'h8 && cap_rd_ptr_i == 2'h3
    && cap_src_sel_i[1] == SRC_TIMER_B) ##1 cap_rd_ptr_i == 2'h3
    |=> {cap_rd_hi_o, cap_rd_lo_o} == $past(tmr_b_count_i, 2))
    else $error("timer b capture wrong");
endmodule : tcc_monitor
bind tcc_top tcc_monitor u_tcc_monitor (.*);

// >>> sim/tcc_pin_model.sv
`timescale 1ns/1ps
// ======================================================================
// outside world driving the two capture pins
module tcc_pin_model (
  // clock
  input wire logic clock_i,
  // wanted levels and noise pulses
  input wire logic [1:0] want_i,
  input wire logic [1:0] noise_i,
  // capture pins
  output logic capture_input_zero_o = 1'h0,
  output logic capture_input_one_o = 1'h0
);
  // pins move on the falling edge, out of step with sampling
  always @(negedge clock_i) begin
    capture_input_zero_o <= want_i[0] ^ noise_i[0];
    capture_input_one_o <= want_i[1] ^ noise_i[1];
  end
endmodule : tcc_pin_model

// >>> sim/testbench.sv
`timescale 1ns/1ps
// ======================================================================
// self-checking bench for the capture/compare unit
module testbench;
  import tcc_pkg::*;
  // design pins
  logic clock_i, srst_i, tmr_a_underflow_i, tmr_a_running_i;
  logic [CNT_W-1:0] tmr_a_count_i, tmr_a_reload_i, tmr_b_count_i;
  logic [CNT_W-1:0] tmr_b_reload_i;
  logic tmr_b_underflow_i, tmr_b_running_i, cmp_wr_lo_i, cmp_wr_hi_i;
  logic [CMP_PTR_W-1:0] cmp_wr_ptr_i;
  logic [7:0] cmp_wr_byte_i, cap_rd_lo_o, cap_rd_hi_o;
  logic capture_input_zero_i, capture_input_one_i;
  logic [CMP_LAT-1:0] cmp_reload_i, cmp_irq_src_i, cmp_match_o, cmp_irq_o;
  logic [CMP_CH-1:0] cmp_src_sel_i, cmp_trig_en_i, cmp_neg_level_i;
  logic [CMP_CH-1:0] cmp_out_o;
  logic [CAP_CH-1:0] cap_src_sel_i, cap_status_o, cap_irq_o;
  logic [2*CAP_CH-1:0] cap_edge_sel_i, cap_filt_sel_i;
  logic [CAP_LAT-1:0] cap_sw_trig_i, cap_sw_trig_rd_o;
  logic [CAP_PTR_W-1:0] cap_rd_ptr_i;
  // bench state
  logic [1:0] pin_want, pin_noise;
  logic [15:0] v, e;
  int failures, tests_run, mt0, mt1, ir0, cq0, cq1;

  tcc_top u_tcc_top (.*);
  tcc_pin_model u_tcc_pin_model (
    .clock_i(clock_i),
    .want_i(pin_want),
    .noise_i(pin_noise),
    .capture_input_zero_o(capture_input_zero_i),
    .capture_input_one_o(capture_input_one_i)
  );

  // 40 MHz clock
  initial begin
    clock_i = 1'h0;
    forever #12.5 clock_i = ~clock_i;
  end

  // timer a stand-in: counts down, reloads, pulses on underflow
  always @(posedge clock_i) begin
    tmr_a_underflow_i <= tmr_a_running_i && tmr_a_count_i == 16'h0000;
    if (tmr_a_running_i) begin
      tmr_a_count_i <= (tmr_a_count_i == 16'h0000) ? tmr_a_reload_i
                                                   : tmr_a_count_i - 16'h0001;
    end
  end

  // pulse counters, cleared between scenarios
  always @(posedge clock_i) begin
    mt0 += cmp_match_o[0];
    mt1 += cmp_match_o[1];
    ir0 += cmp_irq_o[0];
    cq0 += cap_irq_o[0];
    cq1 += cap_irq_o[1];
  end

  // ======================================================================
  // tasks
  task chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk

  task finish_test;
    if (failures == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test

  task tick(input int n);
    repeat (n) @(posedge clock_i);
  endtask : tick

  // counters cleared away from the edge so no race with the counting
  task clr;
    @(negedge clock_i);
    {mt0, mt1, ir0, cq0, cq1} = '0;
  endtask : clr

  task rd(input int k);
    @(posedge clock_i);
    cap_rd_ptr_i <= 2'(k);
    tick(3);
    #1 v = {cap_rd_hi_o, cap_rd_lo_o};
  endtask : rd

  task trig(input int k);
    @(posedge clock_i);
    cap_sw_trig_i <= 4'(1 << k);
    @(posedge clock_i);
    cap_sw_trig_i <= 4'h0;
  endtask : trig

  // low byte staged first, high byte completes the word
  task wr_cmp(input logic [2:0] p, input logic [15:0] d);
    @(posedge clock_i);
    cmp_wr_ptr_i <= p;
    cmp_wr_byte_i <= d[7:0];
    cmp_wr_lo_i <= 1'h1;
    @(posedge clock_i);
    cmp_wr_byte_i <= d[15:8];
    cmp_wr_lo_i <= 1'h0;
    cmp_wr_hi_i <= 1'h1;
    @(posedge clock_i);
    cmp_wr_hi_i <= 1'h0;
  endtask : wr_cmp

  task pulse(input logic [1:0] n, input int len);
    @(posedge clock_i);
    pin_noise <= n;
    tick(len);
    pin_noise <= 2'h0;
  endtask : pulse

  task run(input logic [15:0] c);
    @(posedge clock_i);
    tmr_a_count_i <= c;
    tmr_a_running_i <= 1'h1;
  endtask : run

  task halt;
    @(posedge clock_i);
    tmr_a_running_i <= 1'h0;
  endtask : halt

  // hang guard
  initial begin
    tick(60000);
    failures++;
    finish_test();
  end

  // ======================================================================
  // main sequence
  initial begin
    srst_i = 1'h1;
    tmr_a_count_i = 16'h0100;
    tmr_a_reload_i = 16'h00ff;
    tmr_b_count_i = 16'h0100;
    tmr_b_reload_i = 16'h0040;
    {tmr_a_underflow_i, tmr_a_running_i, tmr_b_underflow_i, tmr_b_running_i,
     cmp_wr_ptr_i, cmp_wr_byte_i, cmp_wr_lo_i, cmp_wr_hi_i, cmp_reload_i,
     cmp_src_sel_i, cmp_trig_en_i, cmp_neg_level_i, cmp_irq_src_i,
     cap_edge_sel_i, cap_filt_sel_i, cap_sw_trig_i, cap_rd_ptr_i,
     pin_want, pin_noise} = '0;
    cap_src_sel_i = 2'h2;
    failures = 0;
    tests_run = 0;
    tick(20);
    srst_i <= 1'h0;
    rd(0);
    chk(v, CAP_RST);
    chk(16'(cmp_out_o), 16'h0000);
    chk(16'(cap_sw_trig_rd_o), 16'h0000);
    // software triggers, each channel on each timer
    for (int s = 0; s < 2; s++) begin
      @(posedge clock_i);
      cap_src_sel_i <= s ? 2'h1 : 2'h2;
      for (int k = 0; k < 4; k++) begin
        @(posedge clock_i);
        e = 16'(16'h1357 + k * 16'h0f0f + s * 16'h0101);
        cap_rd_ptr_i <= 2'(k);
        tmr_a_count_i <= e;
        tmr_b_count_i <= ~e;
        trig(k);
        tick(2);
        #1 chk({cap_rd_hi_o, cap_rd_lo_o}, cap_src_sel_i[k/2] ? ~e : e);
        chk(16'(cap_status_o[k/2]), 16'(k % 2));
      end
    end
    // pin edges: channel 0 filtered, channel 1 filter stopped
    @(posedge clock_i);
    cap_src_sel_i <= 2'h0;
    cap_filt_sel_i <= {FILT_STOP, FILT_DIV1};
    cap_edge_sel_i <= 4'h1;
    tmr_a_count_i <= 16'h0aa0;
    tick(4);
    clr();
    @(posedge clock_i);
    pin_want <= 2'h1;
    tick(14);
    rd(0);
    chk(v, 16'h0aa0);
    chk(16'(cap_status_o[0]), 16'h0000);
    chk(16'(cq0), 16'h0001);
    @(posedge clock_i);
    tmr_a_count_i <= 16'h0bb0;
    pin_want <= 2'h0;
    tick(14);
    rd(1);
    chk(v, 16'h0bb0);
    chk(16'(cap_status_o[0]), 16'h0001);
    chk(16'(cq0), 16'h0001);
    @(posedge clock_i);
    tmr_a_count_i <= 16'h0cc0;
    pulse(2'h1, 3);
    tick(14);
    rd(0);
    chk(v, 16'h0aa0);
    pulse(2'h2, 2);
    tick(14);
    rd(2);
    chk(v, 16'h0cc0);
    rd(3);
    chk(v, 16'h0cc0);
    chk(16'(cq1), 16'h0000);
    // compare: latches loaded while the timer is stopped
    @(posedge clock_i);
    cmp_trig_en_i <= 4'hf;
    cmp_irq_src_i <= 8'hff;
    tmr_a_reload_i <= 16'h0040;
    tmr_a_count_i <= 16'h0100;
    wr_cmp(3'h0, 16'h0010);
    wr_cmp(3'h1, 16'h0030);
    clr();
    run(16'h0040);
    tick(56);
    chk(16'(cmp_out_o[0]), 16'h0001);
    tick(65);
    chk(16'(mt0), 16'h0002);
    chk(16'(mt1), 16'h0002);
    chk(16'(ir0), 16'h0002);
    // x1 above the reload value, timer started higher still
    halt();
    wr_cmp(3'h1, 16'h0050);
    clr();
    run(16'h0060);
    tick(162);
    chk(16'(mt1), 16'h0000);
    chk(16'(mt0), 16'h0002);
    chk(16'(ir0), 16'h0002);
    chk(16'(cmp_out_o[0]), 16'h0001);
    // trigger off: match still pulses, level held
    halt();
    cmp_trig_en_i <= 4'he;
    cmp_src_sel_i <= 4'he;
    cmp_neg_level_i <= 4'he;
    wr_cmp(3'h1, 16'h0030);
    clr();
    run(16'h0040);
    tick(24);
    chk(16'(mt1), 16'h0001);
    chk(16'(cmp_out_o[0]), 16'h0001);
    // running: new out-of-range value waits for the underflow to land
    wr_cmp(3'h0, 16'h0050);
    @(posedge clock_i);
    cmp_reload_i <= 8'h01;
    @(posedge clock_i);
    cmp_reload_i <= 8'h00;
    clr();
    tick(100);
    chk(16'(mt0), 16'h0001);
    finish_test();
  end
endmodule : testbench
